//--- src/cra_device.sv
`timescale 1ns/10ps
`include "cra_params.svh"
module cra_device #(
    parameter int PSIZE_MAX = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    cra_link_if.dev link,
    output logic cfg_wr,
    output logic cfg_rd,
    output cra_pkg::cra_tgt_e cfg_tgt,
    output logic [15:0] cfg_addr,
    output logic [7:0] cfg_size,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ok
);
    import cra_pkg::*;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [2:0] {
        CRA_IDLE = 3'h0,
        CRA_CHAN = 3'h1,
        CRA_ADDR = 3'h3,
        CRA_SIZE = 3'h2,
        CRA_DATA = 3'h6,
        CRA_TAIL = 3'h7,
        CRA_EXEC = 3'h5,
        CRA_RESP = 3'h4
    } cra_st_e;

    cra_st_e st_ff, nxt_st;
    logic [7:0] op_ff;
    logic [2:0] cnt_ff;
    logic bad_ff;
    cra_chan_t chan_ff;
    logic [15:0] addr_ff;
    logic [7:0] size_ff;
    logic [31:0] data_ff;
    cra_tgt_e tgt_ff;
    logic ok_ff;
    logic [2:0] rcnt_ff;
    logic [1:0] rph_ff;

    // ****************************************
    // Decode
    // ****************************************
    wire beat = link.req_valid && link.req_ready;
    wire is_wr = (op_ff == `CRA_CT_WR) || (op_ff == `CRA_CT_PWR);
    wire is_peri = (op_ff == `CRA_CT_PWR) || (op_ff == `CRA_CT_PRD);
    wire is_known = (link.req_data == `CRA_CT_WR) || (link.req_data == `CRA_CT_RD) ||
                    (link.req_data == `CRA_CT_PWR) || (link.req_data == `CRA_CT_PRD);
    wire [7:0] dest_lo = link.req_dest[7:0];
    wire [15:0] dest_lo16 = link.req_dest[15:0];
    wire [2:0] addr_len = is_peri ? 3'h1 : `CRA_REG16_BYTES;
    wire no_reply = is_wr && !bad_ff && (chan_ff[7:0] == `CRA_NORPLY);
    wire [2:0] rd_len = is_peri ? size_ff[2:0] : `CRA_WORD_BYTES;
    wire send_data = ok_ff && !is_wr && !bad_ff;
    wire last_byte = (cnt_ff == 3'h1);
    wire tail_end = beat && link.req_ctl && (link.req_data == `CRA_CT_END);
    wire size_bad = (link.req_data == 8'h00) || (link.req_data > 8'(PSIZE_MAX));

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            CRA_IDLE: if (beat && link.req_ctl) nxt_st = CRA_CHAN;
            CRA_CHAN: if (beat && last_byte) nxt_st = bad_ff ? CRA_TAIL : CRA_ADDR;
            CRA_ADDR: if (beat && last_byte) nxt_st = is_peri ? CRA_SIZE :
                                                     (is_wr ? CRA_DATA : CRA_TAIL);
            CRA_SIZE: if (beat) nxt_st = (is_wr && !size_bad) ? CRA_DATA : CRA_TAIL;
            CRA_DATA: if (beat && last_byte) nxt_st = CRA_TAIL;
            CRA_TAIL: if (tail_end) nxt_st = bad_ff ? CRA_RESP : CRA_EXEC;
            CRA_EXEC: nxt_st = no_reply ? CRA_IDLE : CRA_RESP;
            CRA_RESP: if (link.rsp_ready && rph_ff == 2'h2) nxt_st = CRA_IDLE;
            default: nxt_st = CRA_IDLE;
        endcase
    end

    assign link.req_ready = (st_ff != CRA_EXEC) && (st_ff != CRA_RESP);

    // ****************************************
    // Request capture
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_ff <= CRA_IDLE;
            op_ff <= 8'h00;
            cnt_ff <= 3'h0;
            bad_ff <= 1'b0;
            chan_ff <= 24'h000000;
            addr_ff <= 16'h0000;
            size_ff <= 8'h00;
            data_ff <= 32'h00000000;
            tgt_ff <= CRA_TGT_TILE;
        end else begin
            st_ff <= nxt_st;
            if (st_ff == CRA_IDLE && beat && link.req_ctl) begin
                op_ff <= link.req_data;
                bad_ff <= !is_known;
                cnt_ff <= `CRA_RPLY_BYTES;
                addr_ff <= 16'h0000;
                data_ff <= 32'h00000000;
                size_ff <= 8'h00;
                if (dest_lo == `CRA_PERI_LOW) tgt_ff <= CRA_TGT_PERI;
                else if (dest_lo16 == `CRA_NODE_LOW) tgt_ff <= CRA_TGT_NODE;
                else tgt_ff <= CRA_TGT_TILE;
            end else if (beat) begin
                unique case (st_ff)
                    CRA_CHAN: begin
                        chan_ff <= {chan_ff[15:0], link.req_data};
                        cnt_ff <= last_byte ? addr_len : cnt_ff - 3'h1;
                        if (last_byte && !bad_ff && is_peri != (tgt_ff == CRA_TGT_PERI))
                            bad_ff <= 1'b1;
                    end
                    CRA_ADDR: begin
                        addr_ff <= {addr_ff[7:0], link.req_data};
                        cnt_ff <= last_byte ? `CRA_WORD_BYTES : cnt_ff - 3'h1;
                    end
                    CRA_SIZE: begin
                        size_ff <= link.req_data;
                        cnt_ff <= link.req_data[2:0];
                        if (size_bad) bad_ff <= 1'b1;
                    end
                    CRA_DATA: begin
                        data_ff <= {data_ff[23:0], link.req_data};
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                    CRA_TAIL: if (!tail_end) bad_ff <= 1'b1;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Register access and reply
    // ****************************************
    assign cfg_wr = (st_ff == CRA_EXEC) && is_wr && !bad_ff;
    assign cfg_rd = (st_ff == CRA_EXEC) && !is_wr && !bad_ff;
    assign cfg_tgt = tgt_ff;
    assign cfg_addr = addr_ff;
    assign cfg_size = size_ff;
    assign cfg_wdata = data_ff;

    logic [31:0] rdat_ff;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ok_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
            rcnt_ff <= 3'h0;
            rph_ff <= 2'h0;
        end else if (st_ff == CRA_EXEC) begin
            ok_ff <= cfg_ok && !bad_ff;
            rdat_ff <= cfg_rdata;
            rcnt_ff <= rd_len;
            rph_ff <= 2'h0;
        end else if (st_ff == CRA_TAIL && tail_end && bad_ff) begin
            ok_ff <= 1'b0;
            rph_ff <= 2'h0;
        end else if (st_ff == CRA_RESP && link.rsp_ready) begin
            unique case (rph_ff)
                2'h0: rph_ff <= send_data ? 2'h1 : 2'h2;
                2'h1: begin
                    rcnt_ff <= rcnt_ff - 3'h1;
                    if (rcnt_ff == 3'h1) rph_ff <= 2'h2;
                end
                default: rph_ff <= 2'h0;
            endcase
        end
    end

    // Read data leaves from the top of the requested width
    wire [7:0] rbyte = rdat_ff[{rcnt_ff[1:0] - 2'h1, 3'h0} +: 8];

    assign link.rsp_valid = (st_ff == CRA_RESP);
    assign link.rsp_ctl = (rph_ff != 2'h1);
    assign link.rsp_data = (rph_ff == 2'h0) ? (ok_ff ? `CRA_CT_ACK : `CRA_CT_NACK) :
                           (rph_ff == 2'h1) ? rbyte : `CRA_CT_END;
    assign link.rsp_dest = chan_ff;
endmodule : cra_device

//--- pkg/cra_params.svh
`ifndef CRA_PARAMS_SVH
`define CRA_PARAMS_SVH
`define CRA_CT_END 8'h01
`define CRA_CT_ACK 8'h03
`define CRA_CT_NACK 8'h04
`define CRA_CT_PWR 8'h24
`define CRA_CT_PRD 8'h25
`define CRA_CT_WR 8'hc0
`define CRA_CT_RD 8'hc1
`define CRA_NORPLY 8'hff
`define CRA_RPLY_BYTES 3'h3
`define CRA_REG16_BYTES 3'h2
`define CRA_WORD_BYTES 3'h4
`define CRA_PS_SHIFT 8
`define CRA_PS_RES 32'h0000000b
`define CRA_TILE_LOW 16'hc20c
`define CRA_NODE_LOW 16'hc30c
`define CRA_PERI_LOW 8'h02
`endif

//--- pkg/cra_pkg.sv
package cra_pkg;
    typedef logic [7:0] cra_byte_t;
    typedef logic [23:0] cra_chan_t;
    typedef enum logic [1:0] {
        CRA_TGT_TILE = 2'h0,
        CRA_TGT_NODE = 2'h1,
        CRA_TGT_PERI = 2'h2
    } cra_tgt_e;
endpackage : cra_pkg

//--- pkg/cra_link_if.sv
`timescale 1ns/10ps
// Token link: each beat is one byte, ctl marks a control token
interface cra_link_if;
    logic req_valid;
    logic req_ready;
    logic req_ctl;
    logic [7:0] req_data;
    logic [31:0] req_dest;
    logic rsp_valid;
    logic rsp_ready;
    logic rsp_ctl;
    logic [7:0] rsp_data;
    logic [23:0] rsp_dest;
    modport dev (
        input req_valid, req_ctl, req_data, req_dest, rsp_ready,
        output req_ready, rsp_valid, rsp_ctl, rsp_data, rsp_dest
    );
    modport req (
        output req_valid, req_ctl, req_data, req_dest, rsp_ready,
        input req_ready, rsp_valid, rsp_ctl, rsp_data, rsp_dest
    );
endinterface : cra_link_if

//--- src/cra_requester.sv
`timescale 1ns/10ps
`include "cra_params.svh"
module cra_requester (
    input wire logic clk_sys,
    input wire logic resetn,
    cra_link_if.req link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_wr,
    input wire cra_pkg::cra_tgt_e cmd_tgt,
    input wire logic [15:0] cmd_node,
    input wire logic [7:0] cmd_periph,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_size,
    input wire logic [31:0] cmd_wdata,
    input wire cra_pkg::cra_chan_t cmd_reply,
    input wire logic [7:0] cmd_ps_reg,
    output logic [31:0] ps_resid,
    output logic done,
    output logic done_ok,
    output logic [31:0] done_rdata
);
    import cra_pkg::*;

    // ****************************************
    // Message builder
    // ****************************************
    logic [7:0] msg_ff [0:11];
    logic [11:0] ctl_ff;
    logic [3:0] len_ff, idx_ff;
    logic busy_ff, wait_ff, wr_ff, nor_ff;
    logic [31:0] dest_ff, rd_ff;
    logic [1:0] ph_ff;
    logic ok_ff;
    logic [7:0] m [0:11];
    logic [11:0] mctl;
    logic [3:0] mlen;
    logic [31:0] mdest;
    wire peri = (cmd_tgt == CRA_TGT_PERI);
    wire [3:0] sz = {1'b0, cmd_size[2:0]};

    assign ps_resid = ({24'h000000, cmd_ps_reg} << `CRA_PS_SHIFT) | `CRA_PS_RES;

    always_comb begin
        mctl = 12'h001;
        for (int i = 0; i < 12; i++) m[i] = 8'h00;
        m[0] = peri ? (cmd_wr ? `CRA_CT_PWR : `CRA_CT_PRD) : (cmd_wr ? `CRA_CT_WR : `CRA_CT_RD);
        m[1] = cmd_reply[23:16];
        m[2] = cmd_reply[15:8];
        m[3] = cmd_reply[7:0];
        if (peri) begin
            m[4] = cmd_addr[7:0];
            m[5] = cmd_size;
            for (int i = 0; i < 4; i++)
                if (4'(i) < sz) m[6 + i] = cmd_wdata[8 * (sz - 4'(i) - 4'h1) +: 8];
            mlen = cmd_wr ? 4'h7 + sz : 4'h7;
            mdest = {cmd_node, cmd_periph, `CRA_PERI_LOW};
        end else begin
            m[4] = cmd_addr[15:8];
            m[5] = cmd_addr[7:0];
            for (int i = 0; i < 4; i++) m[6 + i] = cmd_wdata[31 - 8 * i -: 8];
            mlen = cmd_wr ? 4'hb : 4'h7;
            mdest = {cmd_node, (cmd_tgt == CRA_TGT_NODE) ? `CRA_NODE_LOW : `CRA_TILE_LOW};
        end
        m[mlen - 4'h1] = `CRA_CT_END;
        mctl[mlen - 4'h1] = 1'b1;
    end

    assign cmd_ready = !busy_ff;
    assign link.req_valid = busy_ff && !wait_ff;
    assign link.req_data = msg_ff[idx_ff];
    assign link.req_ctl = ctl_ff[idx_ff];
    assign link.req_dest = dest_ff;
    assign link.rsp_ready = wait_ff;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 12; i++) msg_ff[i] <= 8'h00;
            ctl_ff <= 12'h000;
            len_ff <= 4'h0;
            idx_ff <= 4'h0;
            busy_ff <= 1'b0;
            wait_ff <= 1'b0;
            wr_ff <= 1'b0;
            nor_ff <= 1'b0;
            dest_ff <= 32'h00000000;
            rd_ff <= 32'h00000000;
            ph_ff <= 2'h0;
            ok_ff <= 1'b0;
            done <= 1'b0;
            done_ok <= 1'b0;
            done_rdata <= 32'h00000000;
        end else begin
            done <= 1'b0;
            if (!busy_ff && cmd_valid) begin
                for (int i = 0; i < 12; i++) msg_ff[i] <= m[i];
                ctl_ff <= mctl;
                len_ff <= mlen;
                idx_ff <= 4'h0;
                busy_ff <= 1'b1;
                wr_ff <= cmd_wr;
                nor_ff <= cmd_wr && (cmd_reply[7:0] == `CRA_NORPLY);
                dest_ff <= mdest;
                rd_ff <= 32'h00000000;
                ph_ff <= 2'h0;
            end else if (link.req_valid && link.req_ready) begin
                idx_ff <= idx_ff + 4'h1;
                if (idx_ff == len_ff - 4'h1) begin
                    if (nor_ff) begin
                        busy_ff <= 1'b0;
                        done <= 1'b1;
                        done_ok <= 1'b1;
                    end else wait_ff <= 1'b1;
                end
            end else if (wait_ff && link.rsp_valid) begin
                if (ph_ff == 2'h0) begin
                    ok_ff <= (link.rsp_data == `CRA_CT_ACK);
                    ph_ff <= 2'h1;
                end else if (!link.rsp_ctl) begin
                    rd_ff <= {rd_ff[23:0], link.rsp_data};
                end else begin
                    wait_ff <= 1'b0;
                    busy_ff <= 1'b0;
                    done <= 1'b1;
                    done_ok <= ok_ff;
                    done_rdata <= rd_ff;
                end
            end
        end
    end
endmodule : cra_requester

//--- verification/cra_link_properties.sv
`timescale 1ns/10ps
module cra_link_properties (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_ctl,
    input wire logic [7:0] req_data,
    input wire logic [31:0] req_dest,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic rsp_ctl,
    input wire logic [7:0] rsp_data,
    input wire logic [23:0] rsp_dest
);
    // ****************
    // Message start tracking
    // ****************
    logic open_ff;
    logic nxt_open;
    wire req_hs = req_valid && req_ready;
    wire rsp_hs = rsp_valid && rsp_ready;
    wire req_end = req_hs && req_ctl && req_data == 8'h01;
    assign nxt_open = req_hs ? req_end : open_ff;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            open_ff <= 1'b1;
        end else begin
            open_ff <= nxt_open;
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_nack;
        rsp_hs && rsp_ctl && rsp_data == 8'h04;
    endsequence
    sequence s_close;
        rsp_hs && rsp_ctl && rsp_data == 8'h01;
    endsequence
    a_req_hold: assert property (req_valid && !req_ready |=> req_valid
        && $stable({req_ctl, req_data, req_dest})) else $error("request beat changed");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid
        && $stable({rsp_ctl, rsp_data, rsp_dest})) else $error("reply beat changed");
    a_open_token: assert property (req_hs && open_ff |-> req_ctl
        && req_data inside {8'hc0, 8'hc1, 8'h24, 8'h25}) else $error("bad opening token");
    a_peri_dest: assert property (req_hs && open_ff && req_data[7:1] == 7'h12
        |-> req_dest[7:0] == 8'h02) else $error("bad peripheral destination");
    a_cfg_dest: assert property (req_hs && open_ff && req_data[7:1] == 7'h60
        |-> req_dest[15:0] inside {16'hc20c, 16'hc30c}) else $error("bad config destination");
    a_exec_refuse: assert property (req_end |=> !req_ready)
        else $error("beat accepted after closing token");
    a_rsp_first: assert property ($rose(rsp_valid) |-> rsp_ctl
        && rsp_data inside {8'h03, 8'h04}) else $error("bad first reply token");
    a_nack_bound: assert property (s_nack |=> ##[0:8] rsp_hs)
        else $error("failure reply not closed");
    a_nack_close: assert property (s_nack |=> rsp_valid && rsp_ctl
        && rsp_data == 8'h01) else $error("failure reply not followed by closing token");
endmodule : cra_link_properties

//--- verification/config_register_message_access_tb.sv
`timescale 1ns/10ps
module config_register_message_access_tb;
    import cra_pkg::*;
    typedef struct packed {
        logic wr;
        cra_tgt_e tgt;
        logic [15:0] addr;
        logic [7:0] size;
        logic [31:0] wdata;
        logic [23:0] reply;
        logic [31:0] rdata;
        logic ok;
    } cra_row_s;
    logic clk_sys, resetn, cmd_valid, cmd_ready, cmd_wr, done, done_ok, cfg_wr, cfg_rd, cfg_ok;
    logic p_wr, got_ok;
    cra_tgt_e cmd_tgt, cfg_tgt, p_tgt;
    logic [15:0] cmd_node, cmd_addr, cfg_addr, p_addr;
    logic [7:0] cmd_periph, cmd_size, cmd_ps_reg, cfg_size, p_size;
    logic [31:0] cmd_wdata, ps_resid, done_rdata, cfg_wdata, cfg_rdata, p_wdata, got_rd, dest0;
    logic [23:0] cmd_reply, exp_dest;
    logic [8:0] rq[$], rs[$], eq[$], er[$];
    int err_count, samples_checked, cyc, np;
    cra_row_s rows[10] = '{
        '{1'b1, CRA_TGT_TILE, 16'h1234, 8'h00, 32'ha1b2c3d4, 24'h012345, 32'h0, 1'b1},
        '{1'b0, CRA_TGT_TILE, 16'h0010, 8'h00, 32'h0, 24'h012346, 32'h55667788, 1'b1},
        '{1'b1, CRA_TGT_NODE, 16'h00ff, 8'h00, 32'h0badf00d, 24'h100001, 32'h0, 1'b0},
        '{1'b0, CRA_TGT_NODE, 16'h8001, 8'h00, 32'h0, 24'h100002, 32'hdeadbeef, 1'b0},
        '{1'b0, CRA_TGT_NODE, 16'hfffe, 8'h00, 32'h0, 24'h2a0003, 32'h13579bdf, 1'b1},
        '{1'b1, CRA_TGT_PERI, 16'h0733, 8'h04, 32'h01020304, 24'h300004, 32'h0, 1'b1},
        '{1'b0, CRA_TGT_PERI, 16'h0944, 8'h04, 32'h0, 24'h300005, 32'h89abcdef, 1'b1},
        '{1'b0, CRA_TGT_PERI, 16'h0955, 8'h00, 32'h0, 24'h300006, 32'h11111111, 1'b1},
        '{1'b0, CRA_TGT_PERI, 16'h0966, 8'h05, 32'h0, 24'h300007, 32'h22222222, 1'b1},
        '{1'b1, CRA_TGT_NODE, 16'h0042, 8'h00, 32'hcafe0001, 24'h5a01ff, 32'h0, 1'b1}};
    cra_link_if link ();
    cra_device #(.PSIZE_MAX(4)) i_cra_device (.clk_sys, .resetn, .link(link.dev), .cfg_wr,
        .cfg_rd, .cfg_tgt, .cfg_addr, .cfg_size, .cfg_wdata, .cfg_rdata, .cfg_ok);
    cra_requester i_cra_requester (.clk_sys, .resetn, .link(link.req), .cmd_valid, .cmd_ready,
        .cmd_wr, .cmd_tgt, .cmd_node, .cmd_periph, .cmd_addr, .cmd_size, .cmd_wdata, .cmd_reply,
        .cmd_ps_reg, .ps_resid, .done, .done_ok, .done_rdata);
    cra_link_properties i_cra_link_properties (.clk_sys, .resetn,
        .req_valid(link.req_valid), .req_ready(link.req_ready), .req_ctl(link.req_ctl),
        .req_data(link.req_data), .req_dest(link.req_dest), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_ctl(link.rsp_ctl), .rsp_data(link.rsp_data),
        .rsp_dest(link.rsp_dest));
    // ****************
    // Checking helpers
    // ****************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp_q(input logic [8:0] q[$], input logic [8:0] e[$]);
        chk(q.size(), e.size());
        foreach (e[i]) chk(q[i], e[i]);
    endtask : cmp_q
    // Expected link beats, control flag above the byte, multibyte fields high byte first
    function automatic void fill(cra_row_s r, logic pl);
        int n;
        logic pe;
        pe = r.tgt == CRA_TGT_PERI;
        n = r.wr ? (pe ? int'(r.size) : 4) : 0;
        eq = '{{1'b1, pe ? (r.wr ? 8'h24 : 8'h25) : (r.wr ? 8'hc0 : 8'hc1)}};
        for (int i = 2; i >= 0; i--) eq.push_back({1'b0, r.reply[8*i +: 8]});
        eq.push_back({1'b0, pe ? 8'h00 : r.addr[15:8]});
        eq.push_back({1'b0, pe ? r.size : r.addr[7:0]});
        if (pe) eq[4] = {1'b0, r.addr[7:0]};
        for (int i = n - 1; i >= 0; i--) eq.push_back({1'b0, r.wdata[8*i +: 8]});
        eq.push_back(9'h101);
        er = (pl && r.ok) ? '{9'h103} : '{9'h104};
        if (pl && r.ok && !r.wr) for (int i = 3; i >= 0; i--) er.push_back({1'b0, r.rdata[8*i +: 8]});
        er.push_back(9'h101);
    endfunction : fill
    task automatic run_row(cra_row_s r);
        int k;
        logic pl;
        pl = !(r.tgt == CRA_TGT_PERI && (r.size == 8'h00 || r.size > 8'h04));
        fill(r, pl);
        rq = {};
        rs = {};
        np = 0;
        exp_dest = r.reply;
        cfg_rdata <= r.rdata;
        cfg_ok <= r.ok;
        cmd_wr <= r.wr;
        cmd_tgt <= r.tgt;
        cmd_addr <= r.addr;
        cmd_size <= r.size;
        cmd_wdata <= r.wdata;
        cmd_reply <= r.reply;
        cmd_node <= r.reply[23:8];
        cmd_periph <= r.addr[15:8];
        cmd_valid <= 1'b1;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        k = 0;
        do @(posedge clk_sys); while (done !== 1'b1 && k++ < 300);
        got_ok = done_ok;
        got_rd = done_rdata;
        repeat (8) @(posedge clk_sys);
        cmp_q(rq, eq);
        chk(dest0, r.tgt == CRA_TGT_PERI ? {r.reply[23:8], r.addr[15:8], 8'h02} : {r.reply[23:8],
            r.tgt == CRA_TGT_NODE ? 16'hc30c : 16'hc20c});
        chk(np, pl);
        if (pl) chk({p_wr, p_tgt, p_addr}, {r.wr, r.tgt, r.tgt == CRA_TGT_PERI ? {8'h00,
            r.addr[7:0]} : r.addr});
        if (pl && r.wr) chk(p_wdata, r.wdata);
        if (pl && r.tgt == CRA_TGT_PERI) chk(p_size, r.size);
        if (r.wr && r.reply[7:0] == 8'hff) begin
            chk(rs.size(), 0);
        end else begin
            cmp_q(rs, er);
            chk(got_ok, pl && r.ok);
            if (pl && r.ok && !r.wr) chk(got_rd, r.rdata);
        end
    endtask : run_row
    // ****************
    // Clock, monitor and timeout
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (link.req_valid && link.req_ready) begin
            if (rq.size() == 0) dest0 = link.req_dest;
            rq.push_back({link.req_ctl, link.req_data});
        end
        if (link.rsp_valid && link.rsp_ready) begin
            rs.push_back({link.rsp_ctl, link.rsp_data});
            chk(link.rsp_dest, exp_dest);
        end
        if (cfg_wr || cfg_rd) begin
            np++;
            p_wr = cfg_wr;
            p_tgt = cfg_tgt;
            p_addr = cfg_addr;
            p_size = cfg_size;
            p_wdata = cfg_wdata;
        end
        if (++cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        resetn = 1'b0;
        {cmd_valid, cmd_wr, cmd_node, cmd_periph, cmd_addr, cmd_size} = '0;
        cmd_tgt = CRA_TGT_TILE;
        {cmd_wdata, cmd_reply, cmd_ps_reg, cfg_rdata, cfg_ok} = '0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk({link.req_valid, link.rsp_valid, done, cfg_wr, cfg_rd}, 0);
        foreach (rows[i]) run_row(rows[i]);
        for (int i = 0; i < 256; i += 51) begin
            cmd_ps_reg <= i[7:0];
            @(posedge clk_sys);
            chk(ps_resid, {16'h0000, i[7:0], 8'h0b});
        end
        report_and_stop();
    end
endmodule : config_register_message_access_tb
